/* inc/urf_pkg.sv */
// constants and types shared by the unprompted record framer
package urf_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ           = 20000000;
    localparam int unsigned SAMPLE_HZ        = 100;
    localparam int unsigned SAMPLE_CYCLES    = CLK_HZ / SAMPLE_HZ;
    // output rate select codes and decimation ratios (100 Hz / rate)
    localparam logic [1:0]  RATE_10HZ        = 2'h0;
    localparam logic [1:0]  RATE_20HZ        = 2'h1;
    localparam logic [1:0]  RATE_50HZ        = 2'h2;
    localparam logic [1:0]  RATE_100HZ       = 2'h3;
    localparam logic [3:0]  DECIM_10HZ       = 4'hA;
    localparam logic [3:0]  DECIM_20HZ       = 4'h5;
    localparam logic [3:0]  DECIM_50HZ       = 4'h2;
    localparam logic [3:0]  DECIM_100HZ      = 4'h1;
    // filter bandwidth select codes
    localparam logic [1:0]  BW_5HZ           = 2'h0;
    localparam logic [1:0]  BW_10HZ          = 2'h1;
    localparam logic [1:0]  BW_20HZ          = 2'h2;
    localparam logic [1:0]  BW_25HZ          = 2'h3;
    localparam int unsigned LAG_FACTOR       = 4;
    // signature
    localparam logic [15:0] SIG_SEED         = 16'hAAAA;
    localparam logic [7:0]  SIG_MSB_BIT_MASK = 8'h80;
    // ascii
    localparam logic [7:0]  ASCII_COMMA      = 8'h2C;
    localparam logic [7:0]  ASCII_CR         = 8'h0D;
    localparam logic [7:0]  ASCII_ZERO       = 8'h30;
    localparam logic [7:0]  ASCII_LC_A       = 8'h61;
    // record layout
    localparam int unsigned TEXT_FIELDS      = 5;
    localparam int unsigned FIELD_CHARS      = 16;
    localparam logic [7:0]  CNT_RESET        = 8'h00;
    localparam int unsigned LAG_DEPTH        = 128;

    typedef enum logic [6:0] {
        URF_IDLE  = 7'h01,
        URF_FIELD = 7'h02,
        URF_COMMA = 7'h04,
        URF_COUNT = 7'h08,
        URF_SIG   = 7'h10,
        URF_CR    = 7'h20,
        URF_WAIT  = 7'h40
    } urf_state_t;
endpackage

/* logic/urf_lag_mem.sv */
// sample delay line memory for the filtered lag
`timescale 1ns/1ps
module urf_lag_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 128
) (
    // clock
    input  wire logic                     clock,
    // write port
    input  wire logic                     wr_en,
    input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
    input  wire logic [WIDTH-1:0]         wr_data,
    // read port
    input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
    output logic      [WIDTH-1:0]         rd_data_ff
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data_ff <= mem[rd_addr];
    end
endmodule

/* logic/urf_framer.sv */
// unprompted ascii record framer with rolling signature
//
// Operation
// RULE1 - records are sent without polling at 10, 20, 50 or 100 Hz as selected.
// RULE2 - output decimates the 100 Hz samples, raw or filtered by mode.
// RULE3 - a record is comma separated ascii of seven fields closed by a carriage return.
// RULE4 - the counter field is decimal, steps by one per record and wraps 255 to 0.
// RULE5 - the signature field is exactly four hex characters of a 16-bit value.
// RULE6 - the signature covers bytes from the first x character through the counter.
// RULE7 - the signature state starts each record at 0xaaaa, high byte upper, low byte lower.
// RULE8 - per byte, lower<<1 plus upper plus byte, plus one if lower bit 7, then shift down.
// RULE9 - the final signature is upper in the high byte and lower in the low byte.
// RULE10 - the receiver recomputes the signature and drops a mismatching record.
// RULE11 - records are spaced by exactly one output period; a slot that finds the previous record still going is skipped.
// RULE12 - sample age at emission stays within one output period; filtered mode emits a sample up to 400/bw samples older than the newest.
// RULE13 - filtered output lags by output rate over bandwidth times four output samples.
// RULE14 - a new measurement is taken every 10 ms from the internal timer.
// RULE15 - the filtered mode uses a 5, 10, 20 or 25 Hz bandwidth at 100 Hz.
// RULE16 - signature digits are lower case hex with leading zeros.
`timescale 1ns/1ps
module urf_framer #(
    parameter int unsigned SAMPLE_CYCLES = urf_pkg::SAMPLE_CYCLES,
    parameter int unsigned FLD_CHARS     = urf_pkg::FIELD_CHARS
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // configuration
    input  wire logic                     enable,
    input  wire logic                     filtered_mode,
    input  wire logic [1:0]               rate_sel,
    input  wire logic [1:0]               filter_bandwidth,
    // measurement and filter sources, five text fields each
    output logic                          meas_trigger_ff,
    input  wire logic [5*FLD_CHARS*8-1:0] raw_text,
    input  wire logic [5*FLD_CHARS*8-1:0] filt_text,
    input  wire logic [5*5-1:0]           raw_len,
    input  wire logic [5*5-1:0]           filt_len,
    // byte stream toward the serial transmitter
    output logic                          tx_valid_ff,
    output logic [7:0]                    tx_data_ff,
    input  wire logic                     tx_ready,
    output logic                          rec_start_ff,
    output logic [15:0]                   sig_value_ff
);
    localparam int unsigned SMPW = 5 * FLD_CHARS * 8 + 25;
    localparam int unsigned AW   = $clog2(urf_pkg::LAG_DEPTH);

    initial begin
        if (SAMPLE_CYCLES < 100 || FLD_CHARS < 1 || FLD_CHARS > 16 ||
            urf_pkg::LAG_DEPTH <= 80) begin
            $error("urf_framer: unsupported parameters");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] sig_step(input logic [15:0] s, input logic [7:0] b);
        logic [7:0] sum;
        sum = 8'({s[6:0], 1'b0} + s[15:8] + b);
        if ((s[7:0] & urf_pkg::SIG_MSB_BIT_MASK) != 8'h00) begin
            sum = 8'(sum + 8'h01);
        end
        return {s[7:0], sum};
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        if (n < 4'hA) begin
            return 8'(urf_pkg::ASCII_ZERO + {4'h0, n});
        end
        return 8'(urf_pkg::ASCII_LC_A + {4'h0, n} - 8'h0A);
    endfunction

    function automatic logic [3:0] decim_of(input logic [1:0] r);
        case (r)
            urf_pkg::RATE_10HZ: decim_of = urf_pkg::DECIM_10HZ;
            urf_pkg::RATE_20HZ: decim_of = urf_pkg::DECIM_20HZ;
            urf_pkg::RATE_50HZ: decim_of = urf_pkg::DECIM_50HZ;
            default:            decim_of = urf_pkg::DECIM_100HZ;
        endcase
    endfunction

    // lag in 100 Hz samples: (rate/bw*4 output samples) * decim = 400/bw
    function automatic logic [6:0] lag_of(input logic [1:0] bw);
        case (bw)
            urf_pkg::BW_5HZ:  lag_of = 7'(400 / 5);
            urf_pkg::BW_10HZ: lag_of = 7'(400 / 10);
            urf_pkg::BW_20HZ: lag_of = 7'(400 / 20);
            default:          lag_of = 7'(400 / 25);
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [31:0]         tick;
        logic [3:0]          decim;
        logic [AW-1:0]       wptr;
        logic [AW-1:0]       fill;
        logic                rd_pend;
        logic                rec_req;
        logic                meas;
        urf_pkg::urf_state_t st;
        logic [SMPW-1:0]     smp;
        logic [2:0]          fld;
        logic [4:0]          pos;
        logic [1:0]          cdig;
        logic [15:0]         sig;
        logic [7:0]          cnt;
        logic                txv;
        logic [7:0]          txd;
        logic                rs;
        logic [15:0]         sigo;
    } urf_regs_t;

    // first sample after reset opens a record slot
    localparam urf_regs_t RESET_STATE = '{
        decim:   urf_pkg::DECIM_100HZ,
        st:      urf_pkg::URF_IDLE,
        sig:     urf_pkg::SIG_SEED,
        cnt:     urf_pkg::CNT_RESET,
        default: '0
    };

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] dec_char(input logic [7:0] c, input logic [1:0] idx);
        logic [7:0] d;
        case (idx)
            2'h2:    d = 8'(c / 8'h64);
            2'h1:    d = 8'((c / 8'h0A) % 8'h0A);
            default: d = 8'(c % 8'h0A);
        endcase
        return 8'(urf_pkg::ASCII_ZERO + d);
    endfunction

    // index of the leading decimal digit, so no leading zeros are sent
    function automatic logic [1:0] top_digit(input logic [7:0] c);
        if (c >= 8'h64) begin
            return 2'h2;
        end
        if (c >= 8'h0A) begin
            return 2'h1;
        end
        return 2'h0;
    endfunction

    function automatic logic [7:0] text_char(input logic [SMPW-1:0] s, input logic [2:0] f,
                                             input logic [4:0] p);
        return s[(int'(f) * FLD_CHARS + int'(p)) * 8 +: 8];
    endfunction

    function automatic logic [4:0] text_len(input logic [SMPW-1:0] s, input logic [2:0] f);
        return s[5 * FLD_CHARS * 8 + int'(f) * 5 +: 5];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    urf_regs_t       state_ff;
    urf_regs_t       nxt_state;
    logic            smp_wr;
    logic [SMPW-1:0] smp_wdata;
    logic [AW-1:0]   smp_raddr;
    logic [SMPW-1:0] smp_rdata;
    logic [AW-1:0]   lag_dist;
    logic            tx_free;
    logic            emit;
    logic            covered;
    logic [7:0]      emit_byte;

    urf_lag_mem #(
        .WIDTH (SMPW),
        .DEPTH (urf_pkg::LAG_DEPTH)
    ) u_lag_mem (
        .clock      (clock),
        .wr_en      (smp_wr),
        .wr_addr    (state_ff.wptr),
        .wr_data    (smp_wdata),
        .rd_addr    (smp_raddr),
        .rd_data_ff (smp_rdata)
    );

    // a new sample lands in the buffer on the last cycle of each 10 ms period
    assign smp_wr    = state_ff.tick == 32'(SAMPLE_CYCLES - 1); // RULE14
    assign smp_wdata = filtered_mode ? {filt_len, filt_text} : {raw_len, raw_text}; // RULE2 RULE15
    // the write pointer has already moved past the newest sample
    assign smp_raddr = AW'(state_ff.wptr - AW'(1) - lag_dist);
    assign tx_free   = !state_ff.txv || tx_ready;

    always_comb begin
        lag_dist = '0;
        if (filtered_mode) begin
            lag_dist = AW'(lag_of(filter_bandwidth)); // RULE13
            // until enough history is held the oldest sample stands in
            if (lag_dist >= state_ff.fill) begin
                lag_dist = AW'(state_ff.fill - AW'(1));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_state         = state_ff;
        emit              = 1'b0;
        covered           = 1'b0;
        emit_byte         = 8'h00;
        nxt_state.meas    = 1'b0;
        nxt_state.rs      = 1'b0;
        nxt_state.rd_pend = 1'b0;
        nxt_state.rec_req = state_ff.rd_pend;
        if (smp_wr) begin
            nxt_state.tick = '0;
            nxt_state.meas = 1'b1; // RULE14
            nxt_state.wptr = AW'(state_ff.wptr + AW'(1));
            if (state_ff.fill != '1) begin
                nxt_state.fill = AW'(state_ff.fill + AW'(1));
            end
            if (state_ff.decim <= 4'h1) begin
                nxt_state.decim   = decim_of(rate_sel); // RULE1 RULE2 RULE11
                nxt_state.rd_pend = 1'b1;
            end else begin
                nxt_state.decim = 4'(state_ff.decim - 4'h1);
            end
        end else begin
            nxt_state.tick = 32'(state_ff.tick + 32'h1);
        end
        if (tx_free) begin
            nxt_state.txv = 1'b0;
        end
        case (state_ff.st)
            urf_pkg::URF_IDLE: begin
                // a slot that finds the previous record still going is skipped
                if (state_ff.rec_req && enable) begin // RULE1 RULE12
                    nxt_state.smp = smp_rdata;
                    nxt_state.fld = 3'h0;
                    nxt_state.pos = 5'h00;
                    nxt_state.sig = urf_pkg::SIG_SEED; // RULE7
                    nxt_state.rs  = 1'b1;
                    nxt_state.st  = urf_pkg::URF_FIELD;
                end
            end
            urf_pkg::URF_FIELD: begin
                if (tx_free) begin
                    emit      = 1'b1;
                    covered   = 1'b1; // RULE6
                    emit_byte = text_char(state_ff.smp, state_ff.fld, state_ff.pos);
                    if ({1'b0, state_ff.pos} + 6'h01 >=
                        {1'b0, text_len(state_ff.smp, state_ff.fld)} ||
                        state_ff.pos == 5'(FLD_CHARS - 1)) begin
                        nxt_state.st = urf_pkg::URF_COMMA;
                    end else begin
                        nxt_state.pos = 5'(state_ff.pos + 5'h01);
                    end
                end
            end
            urf_pkg::URF_COMMA: begin
                if (tx_free) begin
                    emit      = 1'b1;
                    covered   = 1'b1;
                    emit_byte = urf_pkg::ASCII_COMMA; // RULE3
                    if (state_ff.fld == 3'(urf_pkg::TEXT_FIELDS - 1)) begin
                        nxt_state.cdig = top_digit(state_ff.cnt);
                        nxt_state.st   = urf_pkg::URF_COUNT;
                    end else begin
                        nxt_state.fld = 3'(state_ff.fld + 3'h1);
                        nxt_state.pos = 5'h00;
                        nxt_state.st  = urf_pkg::URF_FIELD;
                    end
                end
            end
            urf_pkg::URF_COUNT: begin
                if (tx_free) begin
                    emit      = 1'b1;
                    covered   = 1'b1; // RULE6
                    emit_byte = dec_char(state_ff.cnt, state_ff.cdig); // RULE4
                    if (state_ff.cdig == 2'h0) begin
                        nxt_state.pos = 5'h00;
                        nxt_state.st  = urf_pkg::URF_SIG;
                    end else begin
                        nxt_state.cdig = 2'(state_ff.cdig - 2'h1);
                    end
                end
            end
            urf_pkg::URF_SIG: begin
                // the comma and the signature digits lie outside the coverage
                if (tx_free) begin
                    emit = 1'b1;
                    if (state_ff.pos == 5'h00) begin
                        emit_byte      = urf_pkg::ASCII_COMMA;
                        nxt_state.sigo = state_ff.sig; // RULE9
                    end else begin
                        emit_byte = hex_char(state_ff.sig[(4 - int'(state_ff.pos)) * 4 +: 4]); // RULE5 RULE16
                    end
                    if (state_ff.pos == 5'h04) begin
                        nxt_state.st = urf_pkg::URF_CR;
                    end else begin
                        nxt_state.pos = 5'(state_ff.pos + 5'h01);
                    end
                end
            end
            urf_pkg::URF_CR: begin
                if (tx_free) begin
                    emit          = 1'b1;
                    emit_byte     = urf_pkg::ASCII_CR; // RULE3
                    nxt_state.cnt = 8'(state_ff.cnt + 8'h01); // RULE4
                    nxt_state.st  = urf_pkg::URF_WAIT;
                end
            end
            urf_pkg::URF_WAIT: begin
                // the carriage return is taken before the line goes idle
                if (tx_free) begin
                    nxt_state.st = urf_pkg::URF_IDLE;
                end
            end
            default: begin
                nxt_state.st = urf_pkg::URF_IDLE;
            end
        endcase
        if (emit) begin
            nxt_state.txv = 1'b1;
            nxt_state.txd = emit_byte;
        end
        if (covered) begin
            nxt_state.sig = sig_step(state_ff.sig, emit_byte); // RULE8
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= RESET_STATE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign meas_trigger_ff = state_ff.meas;
    assign tx_valid_ff     = state_ff.txv;
    assign tx_data_ff      = state_ff.txd;
    assign rec_start_ff    = state_ff.rs;
    assign sig_value_ff    = state_ff.sigo;
endmodule

/* verification/urf_framer_monitor.sv */
// port assertions for the record framer
`timescale 1ns/1ps
module urf_framer_monitor #(parameter int unsigned SAMPLE_CYCLES = 100) (
    // clock and setup
    input wire logic       clock,
    input wire logic       sys_rst,
    input wire logic       enable,
    input wire logic [1:0] rate_sel,
    // outputs and transmitter ready
    input wire logic       meas_trigger_ff,
    input wire logic       rec_start_ff,
    input wire logic       tx_valid_ff,
    input wire logic [7:0] tx_data_ff,
    input wire logic       tx_ready
);
    localparam int unsigned NONE = 32'hFFFFFFFF;
    int unsigned t_ff, r_ff, c_ff, per;
    wire logic   cr = tx_valid_ff && tx_ready && tx_data_ff == 8'h0D;
    assign per = SAMPLE_CYCLES * (rate_sel == 0 ? 10 : rate_sel == 1 ? 5 : rate_sel == 2 ? 2 : 1);
    always_ff @(posedge clock) begin
        t_ff <= sys_rst ? NONE : meas_trigger_ff ? 0 : (t_ff == NONE ? NONE : t_ff + 1);
        r_ff <= sys_rst ? NONE : rec_start_ff ? 0 : (r_ff == NONE ? NONE : r_ff + 1);
        c_ff <= (sys_rst || cr) ? 0 : c_ff + (tx_valid_ff && tx_ready && tx_data_ff == 8'h2C);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    hold_valid_a: assert property (tx_valid_ff && !tx_ready |=> tx_valid_ff && $stable(tx_data_ff))
        else $error("stalled byte changed");
    trig_period_a: assert property (meas_trigger_ff && t_ff != NONE |-> t_ff == SAMPLE_CYCLES - 1)
        else $error("sample period wrong");
    trig_pulse_a: assert property (meas_trigger_ff |=> !meas_trigger_ff)
        else $error("trigger too long");
    rec_space_a: assert property (rec_start_ff && r_ff != NONE |-> r_ff == per - 1)
        else $error("record spacing wrong");
    rec_pulse_a: assert property (rec_start_ff |=> !rec_start_ff)
        else $error("record start too long");
    idle_quiet_a: assert property (!enable && !$past(enable) |-> !rec_start_ff)
        else $error("record while disabled");
    cr_commas_a: assert property (cr |-> c_ff == 6)
        else $error("field count wrong");
    cr_gap_a: assert property (cr |=> !tx_valid_ff)
        else $error("byte after record end");
    cover property (rec_start_ff);
    cover property (cr);
    cover property (tx_valid_ff && !tx_ready);
endmodule
bind urf_framer urf_framer_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_mon (.clock, .sys_rst,
    .enable, .rate_sel, .meas_trigger_ff, .rec_start_ff, .tx_valid_ff, .tx_data_ff, .tx_ready);

/* verification/urf_host_model.sv */
// host receiver model that rebuilds each record
`timescale 1ns/1ps
module urf_host_model (
    // clock, reset and stall
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        hold_off,
    // byte stream and decoded record
    input  wire logic        tx_valid_ff,
    input  wire logic [7:0]  tx_data_ff,
    output logic             tx_ready,
    output logic             done = 1'b0,
    output logic [15:0]      sig_seen,
    output logic [15:0]      sig_calc,
    output int               cnt_seen,
    output logic [7:0]       first_ch
);
    logic [7:0] q[$];
    logic [7:0] hi, lo, b;
    int         n;
    assign tx_ready = !hold_off;
    always @(posedge clock) begin
        done <= 1'b0;
        if (sys_rst)
            q.delete();
        else if (tx_valid_ff && tx_ready && tx_data_ff != 8'h0D)
            q.push_back(tx_data_ff);
        else if (tx_valid_ff && tx_ready) begin
            {hi, lo} = urf_pkg::SIG_SEED;
            {n, cnt_seen, sig_seen} = '0;
            first_ch = q[0];
            foreach (q[i]) begin
                n += (q[i] == 8'h2C);
                if (n < 6) begin
                    b = (lo << 1) + hi + q[i] + lo[7];
                    hi = lo;
                    lo = b;
                end else if (q[i] != 8'h2C)
                    sig_seen = {sig_seen[11:0], 4'(q[i] - (q[i] > 8'h39 ? 8'h57 : 8'h30))};
                if (n == 5 && q[i] != 8'h2C) cnt_seen = cnt_seen * 10 + q[i] - 8'h30;
            end
            sig_calc = {hi, lo};
            done <= 1'b1;
            q.delete();
        end
    end
endmodule

/* verification/unprompted_record_framer_tb.sv */
// self-checking bench for the record framer
`timescale 1ns/1ps
module unprompted_record_framer_tb;
    localparam int unsigned SC = 100;
    logic clock = 0, sys_rst = 1, enable = 1, filtered_mode = 0, hold_off = 0, tx_ready, done;
    logic [1:0]   rate_sel = 0, filter_bandwidth = 0;
    logic [639:0] raw_text = '0, filt_text = '0;
    logic [7:0]   tx_data_ff, first_ch, exp_ch, ch;
    logic [15:0]  sig_seen, sig_calc;
    logic         tx_valid_ff;
    int           cnt_seen, exp_cnt = 0, error_cnt = 0, tests_run = 0, recs = 0;
    urf_framer #(.SAMPLE_CYCLES(SC)) dut (.clock, .sys_rst, .enable, .filtered_mode, .rate_sel,
        .filter_bandwidth, .meas_trigger_ff(), .raw_text, .filt_text, .raw_len({5{5'h01}}),
        .filt_len({5{5'h01}}), .tx_valid_ff, .tx_data_ff, .tx_ready, .rec_start_ff(),
        .sig_value_ff());
    urf_host_model host (.clock, .sys_rst, .hold_off, .tx_valid_ff, .tx_data_ff, .tx_ready,
        .done, .sig_seen, .sig_calc, .cnt_seen, .first_ch);
    always #25 clock = ~clock;
    always @(posedge clock) hold_off <= 1'($urandom);
    task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
        tests_run++;
        if (e !== s) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    always @(posedge clock) if (done) begin
        chk("signature", sig_calc, sig_seen);
        chk("counter", 16'(exp_cnt), 16'(cnt_seen));
        chk("source", 16'(exp_ch), 16'(first_ch));
        exp_cnt = (exp_cnt + 1) % 256;
        recs++;
    end
    task automatic run(logic fm, logic [1:0] rs, int n, logic en);
        ch = 8'h30 + 8'($urandom % 10);
        exp_ch = fm ? ch ^ 8'h01 : ch;
        sys_rst <= 1;
        filtered_mode <= fm;
        rate_sel <= rs;
        enable <= en;
        filter_bandwidth <= 2'($urandom);
        raw_text <= {80{ch}};
        filt_text <= {80{ch ^ 8'h01}};
        repeat (12) @(posedge clock);
        sys_rst <= 0;
        exp_cnt = 0;
        recs = 0;
        for (int i = 0; i < (n + 1) * SC * 11 && (recs < n || n == 0); i++) @(posedge clock);
        chk("records", 16'(n), 16'(recs));
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h09928A60));
        for (int m = 0; m < 8; m++) run(m[0], m[2:1], 3, 1);
        run(0, 3, 0, 0);
        run(1, 3, 258, 1);
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge clock);
        error_cnt++;
        report_and_stop();
    end
endmodule
